/* core/dcfg_pkg.sv */
package dcfg_pkg;
  // Serial frame layout
  localparam logic [4:0] INSTR_LAST = 5'h0F;   // Final instruction bit
  localparam logic [4:0] DATA_FIRST = 5'h10;   // First data bit
  localparam logic [4:0] FRAME_LAST = 5'h17;   // Final bit of one byte
  localparam int         FRAME_RW   = 23;      // Read flag in host frame

  // Device register addresses
  localparam logic [14:0] A_PORT     = 15'h000;
  localparam logic [14:0] A_CATEGORY = 15'h003;
  localparam logic [14:0] A_IDENT_LO = 15'h004;
  localparam logic [14:0] A_IDENT_HI = 15'h005;
  localparam logic [14:0] A_GRADE    = 15'h006;
  localparam logic [14:0] A_POWER    = 15'h011;
  localparam logic [14:0] A_CLK_PD   = 15'h080;
  localparam logic [14:0] A_ALIGN_PD = 15'h081;
  localparam logic [14:0] A_PLL_EN   = 15'h083;
  localparam logic [14:0] A_PLL_STAT = 15'h084;
  localparam logic [14:0] A_PLL_FB   = 15'h085;
  localparam logic [14:0] A_PLL_OUT  = 15'h08B;
  localparam logic [14:0] A_PLL_REF  = 15'h08C;
  localparam logic [14:0] A_FORMAT   = 15'h110;
  localparam logic [14:0] A_INTERP   = 15'h112;
  localparam logic [14:0] A_DP_TUNE_A  = 15'h12D;
  localparam logic [14:0] A_DP_TUNE_B  = 15'h146;
  localparam logic [14:0] A_PLL_TUNE   = 15'h1C4;
  localparam logic [14:0] A_LINK_TUNE_A = 15'h232;
  localparam logic [14:0] A_SD_TUNE_A  = 15'h291;
  localparam logic [14:0] A_SD_TUNE_B  = 15'h29C;
  localparam logic [14:0] A_SD_TUNE_C  = 15'h29F;
  localparam logic [14:0] A_CLK_TUNE   = 15'h2A4;
  localparam logic [14:0] A_LINK_TUNE_B = 15'h333;

  // Values written by the setup sequence
  localparam logic [7:0] V_SOFT_RESET = 8'hBD;
  localparam logic [7:0] V_PORT_4WIRE = 8'h3C;
  localparam logic [7:0] V_ALL_ON     = 8'h00;
  localparam logic [7:0] V_ALIGN_SC0  = 8'h10;
  localparam logic [7:0] V_PLL_ENABLE = 8'h10;
  localparam logic [7:0] V_DP_TUNE_A  = 8'h8B;
  localparam logic [7:0] V_DP_TUNE_B  = 8'h01;
  localparam logic [7:0] V_CLK_TUNE   = 8'hFF;
  localparam logic [7:0] V_PLL_TUNE   = 8'h73;
  localparam logic [7:0] V_SD_TUNE_A  = 8'h49;
  localparam logic [7:0] V_SD_TUNE_B  = 8'h24;
  localparam logic [7:0] V_SD_TUNE_C  = 8'h73;
  localparam logic [7:0] V_LINK_TUNE_A = 8'hFF;
  localparam logic [7:0] V_LINK_TUNE_B = 8'h01;

  // Field positions
  localparam int BANDGAP_PD_BIT = 7;
  localparam int MASTER_PD_BIT  = 2;
  localparam int CONV_PD_LSB    = 3;
  localparam int ADDR_INC_BIT   = 5;
  localparam int PLL_EN_BIT     = 4;
  localparam int PLL_LOCK_BIT   = 1;
  localparam int FORMAT_BIT     = 7;
  localparam logic [7:0] SOFT_RESET_MASK = 8'h81;
  localparam logic [7:0] REG_RESET       = 8'h00;

  // Timing
  localparam int CLK_PERIOD_NS  = 40;
  localparam int SCLK_PERIOD_NS = 100;
  localparam int SCLK_HALF_CYC  =
    (SCLK_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] LOCK_POLL_MAX = 8'hC8;

  // Host command register offsets
  localparam logic [2:0] H_CTRL     = 3'h0;
  localparam logic [2:0] H_INTERP   = 3'h1;
  localparam logic [2:0] H_PLL_OUT  = 3'h2;
  localparam logic [2:0] H_PLL_REF  = 3'h3;
  localparam logic [2:0] H_PLL_FB   = 3'h4;
  localparam logic [2:0] H_STATUS   = 3'h5;
  localparam logic [2:0] H_IRQ_STAT = 3'h6;
  localparam logic [2:0] H_IRQ_MASK = 3'h7;
endpackage : dcfg_pkg

/* core/dcfg_if.sv */
`timescale 1ns/1ns
interface dcfg_if;
  logic cs_n;    // Chip select, low during a frame
  logic sclk;    // Serial clock from the host
  logic sdio;    // Host to device data
  logic sdo;     // Device to host data
  logic sdo_oe;  // Device drives sdo
  modport dev  (input cs_n, sclk, sdio, output sdo, sdo_oe);
  modport host (output cs_n, sclk, sdio, input sdo, sdo_oe);
endinterface : dcfg_if

/* core/dcfg_device.sv */
`timescale 1ns/1ns
module dcfg_device #(
  parameter logic [7:0]  CATEGORY_CODE = 8'h5A,   // Arbitrary value
  parameter logic [15:0] PRODUCT_CODE  = 16'h1234, // Arbitrary value
  parameter logic [3:0]  GRADE_CODE    = 4'h3,    // Arbitrary value
  parameter logic [3:0]  REVISION_CODE = 4'h7     // Arbitrary value
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // Serial port
  dcfg_if.dev             spi,
  // Analog status
  input  wire logic       pll_locked,
  // Configuration outputs
  output logic            bandgap_power_down,
  output logic            master_power_down,
  output logic [3:0]      converter_power_down_mask,
  output logic [7:0]      clock_power_down_mask,
  output logic [7:0]      alignment_input_power_down,
  output logic            pll_enable,
  output logic [7:0]      pll_output_divider_select,
  output logic [7:0]      reference_divider_select,
  output logic [7:0]      feedback_divider_count,
  output logic            sample_number_format,
  output logic [7:0]      interpolation_select
);
  localparam int NREG = 19;

  // Index of a writable register, NREG when none
  function automatic logic [4:0] reg_index(input logic [14:0] a);
    unique case (a)
      dcfg_pkg::A_PORT:        reg_index = 5'd0;
      dcfg_pkg::A_POWER:       reg_index = 5'd1;
      dcfg_pkg::A_CLK_PD:      reg_index = 5'd2;
      dcfg_pkg::A_ALIGN_PD:    reg_index = 5'd3;
      dcfg_pkg::A_PLL_EN:      reg_index = 5'd4;
      dcfg_pkg::A_PLL_FB:      reg_index = 5'd5;
      dcfg_pkg::A_PLL_OUT:     reg_index = 5'd6;
      dcfg_pkg::A_PLL_REF:     reg_index = 5'd7;
      dcfg_pkg::A_FORMAT:      reg_index = 5'd8;
      dcfg_pkg::A_INTERP:      reg_index = 5'd9;
      dcfg_pkg::A_DP_TUNE_A:   reg_index = 5'd10;
      dcfg_pkg::A_DP_TUNE_B:   reg_index = 5'd11;
      dcfg_pkg::A_PLL_TUNE:    reg_index = 5'd12;
      dcfg_pkg::A_LINK_TUNE_A: reg_index = 5'd13;
      dcfg_pkg::A_SD_TUNE_A:   reg_index = 5'd14;
      dcfg_pkg::A_SD_TUNE_B:   reg_index = 5'd15;
      dcfg_pkg::A_SD_TUNE_C:   reg_index = 5'd16;
      dcfg_pkg::A_CLK_TUNE:    reg_index = 5'd17;
      dcfg_pkg::A_LINK_TUNE_B: reg_index = 5'd18;
      default:                 reg_index = 5'd19;
    endcase
  endfunction : reg_index

  logic [7:0]  regs_q [NREG];  // Writable register file
  logic        sclk_q;         // Previous serial clock level
  logic [4:0]  cnt_q;          // Bit position in the frame
  logic [14:0] sh_q;           // Incoming bit shifter
  logic        rd_q;           // Frame is a read
  logic [14:0] addr_q;         // Current register address
  logic [7:0]  out_q;          // Outgoing read byte
  logic        sdo_q;          // Bit on the output pin
  logic        lock_q;         // Registered lock status

  // Edge detection on the sampled serial clock
  wire rise = ~spi.cs_n & spi.sclk & ~sclk_q;
  wire fall = ~spi.cs_n & ~spi.sclk & sclk_q;
  wire instr_end = rise & (cnt_q == dcfg_pkg::INSTR_LAST);
  wire byte_end  = rise & (cnt_q == dcfg_pkg::FRAME_LAST);
  wire [7:0] wbyte = {sh_q[6:0], spi.sdio};

  // Address stepping between bytes of a burst
  wire [14:0] next_addr = regs_q[0][dcfg_pkg::ADDR_INC_BIT] ?
                          addr_q + 15'd1 : addr_q - 15'd1;
  // Last address bit is still on the pin at the instruction edge
  wire [14:0] ld_addr = instr_end ? {sh_q[13:0], spi.sdio} :
                        next_addr;  // [RQ15]
  wire [4:0]  ld_idx  = reg_index(ld_addr);
  wire [4:0]  wr_idx  = reg_index(addr_q);
  wire        do_wr   = byte_end & ~rd_q;
  wire        soft_rst = do_wr & (wr_idx == 5'd0) &
                         (|(wbyte & dcfg_pkg::SOFT_RESET_MASK));

  // Read value for the address about to be shifted out
  logic [7:0] rd_val;
  always_comb begin
    rd_val = 8'h00;  // Unmapped addresses read zero
    unique case (ld_addr)
      dcfg_pkg::A_CATEGORY: rd_val = CATEGORY_CODE;  // [RQ1]
      dcfg_pkg::A_IDENT_LO: rd_val = PRODUCT_CODE[7:0];  // [RQ2]
      dcfg_pkg::A_IDENT_HI: rd_val = PRODUCT_CODE[15:8];  // [RQ2]
      dcfg_pkg::A_GRADE:    rd_val = {GRADE_CODE, REVISION_CODE};  // [RQ3]
      dcfg_pkg::A_PLL_STAT: rd_val[dcfg_pkg::PLL_LOCK_BIT] = lock_q; // [RQ13]
      default: if (ld_idx < 5'd19) begin
        rd_val = regs_q[ld_idx];
      end
    endcase
  end

  // Frame bit counter and instruction capture
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sclk_q <= 1'b0;
      cnt_q  <= 5'd0;
      sh_q   <= 15'h0000;
      rd_q   <= 1'b0;
      addr_q <= 15'h0000;
    end else begin
      sclk_q <= spi.sclk;
      if (spi.cs_n) begin
        cnt_q <= 5'd0;  // Select high restarts the instruction phase
      end else if (rise) begin
        sh_q  <= {sh_q[13:0], spi.sdio};
        cnt_q <= byte_end ? dcfg_pkg::DATA_FIRST : cnt_q + 5'd1;
        if (instr_end) begin
          rd_q   <= sh_q[14];  // [RQ15]
          addr_q <= {sh_q[13:0], spi.sdio};  // [RQ15]
        end else if (byte_end) begin
          addr_q <= next_addr;
        end
      end
    end
  end

  // Read shifter, driven out on falling serial edges
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      out_q <= 8'h00;
      sdo_q <= 1'b0;
    end else if (instr_end | byte_end) begin
      out_q <= rd_val;
    end else if (fall & rd_q & (cnt_q >= dcfg_pkg::DATA_FIRST)) begin
      sdo_q <= out_q[7];
      out_q <= {out_q[6:0], 1'b0};
    end
  end

  // Register file; soft reset returns all but the port register to defaults
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NREG; i++) regs_q[i] <= dcfg_pkg::REG_RESET;
    end else if (soft_rst) begin
      for (int i = 0; i < NREG; i++) regs_q[i] <= dcfg_pkg::REG_RESET;
      regs_q[0] <= wbyte & ~dcfg_pkg::SOFT_RESET_MASK;  // Self clearing
    end else if (do_wr & (wr_idx < 5'd19)) begin
      regs_q[wr_idx] <= wbyte;
    end
  end

  // Lock status follows the analog flag only while enabled
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) lock_q <= 1'b0;
    else lock_q <= pll_locked & regs_q[4][dcfg_pkg::PLL_EN_BIT];  // [RQ13]
  end

  // Pins and configuration outputs
  assign spi.sdo    = sdo_q;
  assign spi.sdo_oe = ~spi.cs_n;  // Four-wire output, idle when deselected
  assign bandgap_power_down = regs_q[1][dcfg_pkg::BANDGAP_PD_BIT];
  assign master_power_down  = regs_q[1][dcfg_pkg::MASTER_PD_BIT];
  assign converter_power_down_mask =
    regs_q[1][dcfg_pkg::CONV_PD_LSB +: 4];
  assign clock_power_down_mask      = regs_q[2];
  assign alignment_input_power_down = regs_q[3];
  assign pll_enable = regs_q[4][dcfg_pkg::PLL_EN_BIT];
  assign feedback_divider_count    = regs_q[5];
  assign pll_output_divider_select = regs_q[6];
  assign reference_divider_select  = regs_q[7];
  assign sample_number_format =
    regs_q[8][dcfg_pkg::FORMAT_BIT];  // [RQ14]
  assign interpolation_select = regs_q[9];
endmodule : dcfg_device

/* core/dcfg_host.sv */
`timescale 1ns/1ns
// Function
// RQ1 - Category code read at lowest ident address
// RQ2 - Product identifier split high and low bytes
// RQ3 - Grade upper nibble, revision lower nibble
// RQ4 - Host configures in the fixed stage order
// RQ5 - Soft reset, then release with four-wire
// RQ6 - Clear bandgap and master converter power-down
// RQ7 - Zero converter power-down field, all used
// RQ8 - Zero clock power-down register
// RQ9 - Alignment power-down by subclass choice
// RQ10 - Write mandatory datapath and clock values
// RQ11 - Write mandatory serial-link values after reset
// RQ12 - Program PLL dividers, then enable it
// RQ13 - Lock bit set; host confirms before proceeding
// RQ14 - Format bit selects twos complement or offset
// RQ15 - Instruction: read flag then 15-bit address
// RQ16 - Bounded lock wait reports setup failure
module dcfg_host (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // Software register port
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic [7:0]      rdata,
  // Interrupt
  output logic            irq,
  // Serial port
  dcfg_if.host            spi
);
  // Sequence steps
  localparam logic [4:0] PLL_FIRST = 5'd14;
  localparam logic [4:0] POLL_STEP = 5'd18;
  localparam logic [4:0] POST_PLL  = 5'd19;
  localparam logic [4:0] LAST_STEP = 5'd20;
  localparam logic [3:0] HALF_LAST = 4'(dcfg_pkg::SCLK_HALF_CYC - 1);

  typedef enum logic [2:0] {
    ST_IDLE, ST_LOAD, ST_SHIFT, ST_GAP, ST_CHECK
  } host_state_t;

  // Frame for one sequence step: read flag, address, data
  function automatic logic [23:0] step_frame(
    input logic [4:0] s, input logic sc0, input logic fmt,
    input logic [7:0] interp, input logic [7:0] odiv,
    input logic [7:0] rdiv, input logic [7:0] fb);
    logic [14:0] a;
    logic [7:0]  d;
    logic        r;
    r = 1'b0;
    unique case (s)
      5'd0:  begin a = dcfg_pkg::A_PORT; d = dcfg_pkg::V_SOFT_RESET; end
      5'd1:  begin a = dcfg_pkg::A_PORT; d = dcfg_pkg::V_PORT_4WIRE; end
      5'd2:  begin a = dcfg_pkg::A_POWER; d = dcfg_pkg::V_ALL_ON; end
      5'd3:  begin a = dcfg_pkg::A_CLK_PD; d = dcfg_pkg::V_ALL_ON; end
      5'd4:  begin
        a = dcfg_pkg::A_ALIGN_PD;
        d = sc0 ? dcfg_pkg::V_ALIGN_SC0 : dcfg_pkg::V_ALL_ON;
      end
      5'd5:  begin a = dcfg_pkg::A_DP_TUNE_A; d = dcfg_pkg::V_DP_TUNE_A; end
      5'd6:  begin a = dcfg_pkg::A_DP_TUNE_B; d = dcfg_pkg::V_DP_TUNE_B; end
      5'd7:  begin a = dcfg_pkg::A_CLK_TUNE; d = dcfg_pkg::V_CLK_TUNE; end
      5'd8:  begin a = dcfg_pkg::A_PLL_TUNE; d = dcfg_pkg::V_PLL_TUNE; end
      5'd9:  begin a = dcfg_pkg::A_SD_TUNE_A; d = dcfg_pkg::V_SD_TUNE_A; end
      5'd10: begin a = dcfg_pkg::A_SD_TUNE_B; d = dcfg_pkg::V_SD_TUNE_B; end
      5'd11: begin a = dcfg_pkg::A_SD_TUNE_C; d = dcfg_pkg::V_SD_TUNE_C; end
      5'd12: begin
        a = dcfg_pkg::A_LINK_TUNE_A;
        d = dcfg_pkg::V_LINK_TUNE_A;
      end
      5'd13: begin
        a = dcfg_pkg::A_LINK_TUNE_B;
        d = dcfg_pkg::V_LINK_TUNE_B;
      end
      5'd14: begin a = dcfg_pkg::A_PLL_OUT; d = odiv; end
      5'd15: begin a = dcfg_pkg::A_PLL_REF; d = rdiv; end
      5'd16: begin a = dcfg_pkg::A_PLL_FB; d = fb; end
      5'd17: begin a = dcfg_pkg::A_PLL_EN; d = dcfg_pkg::V_PLL_ENABLE; end
      5'd18: begin a = dcfg_pkg::A_PLL_STAT; d = 8'h00; r = 1'b1; end
      5'd19: begin a = dcfg_pkg::A_INTERP; d = interp; end
      default: begin
        a = dcfg_pkg::A_FORMAT;
        d = {fmt, 7'h00};
      end
    endcase
    step_frame = {r, a, d};
  endfunction : step_frame

  // Software visible state
  logic [3:1] ctrl_q;       // Use PLL, subclass 0, offset binary
  logic [7:0] interp_q;     // Interpolation choice
  logic [7:0] odiv_q;       // PLL output divider
  logic [7:0] rdiv_q;       // PLL reference divider
  logic [7:0] fb_q;         // PLL feedback count
  logic       done_q;       // Last run finished cleanly
  logic       fail_q;       // Last run timed out on lock
  logic       locked_q;     // Lock was confirmed
  logic [1:0] irq_stat_q;   // Sticky done, fail events
  logic [1:0] irq_mask_q;   // Enables for those events
  logic [7:0] rdata_q;      // Read data, one cycle late

  // Sequencer and serial engine state
  host_state_t st_q;
  logic [4:0]  step_q;      // Current step
  logic [7:0]  poll_q;      // Lock polls made
  logic [23:0] frame_q;     // Outgoing frame shifter
  logic [7:0]  rx_q;        // Last eight bits received
  logic [4:0]  bit_q;       // Bit in the frame
  logic [3:0]  half_q;      // Half period counter
  logic        sclk_q;
  logic        cs_n_q;

  // Decodes
  wire start    = wr & (addr == dcfg_pkg::H_CTRL) & wdata[0] &
                  (st_q == ST_IDLE);
  wire tick     = (half_q == HALF_LAST);
  wire lock_ok  = rx_q[dcfg_pkg::PLL_LOCK_BIT];
  wire at_poll  = (step_q == POLL_STEP);
  wire timeout  = at_poll & ~lock_ok & (poll_q == dcfg_pkg::LOCK_POLL_MAX);
  wire finish   = (st_q == ST_CHECK) & ~timeout &
                  (step_q == LAST_STEP) ;
  wire fail_ev  = (st_q == ST_CHECK) & timeout;  // [RQ16]
  wire [1:0] ev = {fail_ev, finish};
  wire [4:0] next_step = (step_q == PLL_FIRST - 5'd1) & ~ctrl_q[1] ?
                         POST_PLL : step_q + 5'd1;  // [RQ12]
  wire [23:0] frame_w = step_frame(step_q, ctrl_q[2], ctrl_q[3],
                                   interp_q, odiv_q, rdiv_q, fb_q);

  // Software writes to the command registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q     <= 3'h0;
      interp_q   <= 8'h00;
      odiv_q     <= 8'h00;
      rdiv_q     <= 8'h00;
      fb_q       <= 8'h00;
      irq_mask_q <= 2'h0;
    end else if (wr) begin
      unique case (addr)
        dcfg_pkg::H_CTRL:     ctrl_q     <= wdata[3:1];
        dcfg_pkg::H_INTERP:   interp_q   <= wdata;
        dcfg_pkg::H_PLL_OUT:  odiv_q     <= wdata;
        dcfg_pkg::H_PLL_REF:  rdiv_q     <= wdata;
        dcfg_pkg::H_PLL_FB:   fb_q       <= wdata;
        dcfg_pkg::H_IRQ_MASK: irq_mask_q <= wdata[1:0];
        default: ;  // Status registers ignore writes
      endcase
    end
  end

  // Read data and sticky events; a new event wins over the read clear
  wire rd_stat = rd & (addr == dcfg_pkg::H_IRQ_STAT);
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q    <= 8'h00;
      irq_stat_q <= 2'h0;
    end else begin
      irq_stat_q <= (rd_stat ? 2'h0 : irq_stat_q) | ev;
      if (rd) begin
        unique case (addr)
          dcfg_pkg::H_CTRL:     rdata_q <= {4'h0, ctrl_q, 1'b0};
          dcfg_pkg::H_INTERP:   rdata_q <= interp_q;
          dcfg_pkg::H_PLL_OUT:  rdata_q <= odiv_q;
          dcfg_pkg::H_PLL_REF:  rdata_q <= rdiv_q;
          dcfg_pkg::H_PLL_FB:   rdata_q <= fb_q;
          dcfg_pkg::H_STATUS:   rdata_q <= {4'h0, locked_q, fail_q,
                                            done_q, st_q != ST_IDLE};
          dcfg_pkg::H_IRQ_STAT: rdata_q <= {6'h00, irq_stat_q};
          default:              rdata_q <= {6'h00, irq_mask_q};
        endcase
      end
    end
  end

  // Step sequencer: stages run strictly in the fixed order
  always_ff @(posedge core_clk or negedge nrst) begin  // [RQ4]
    if (!nrst) begin
      st_q     <= ST_IDLE;
      step_q   <= 5'd0;
      poll_q   <= 8'h00;
      done_q   <= 1'b0;
      fail_q   <= 1'b0;
      locked_q <= 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE: if (start) begin
          st_q <= ST_LOAD;
          step_q <= 5'd0;  // [RQ5]
          poll_q <= 8'h00;
          {done_q, fail_q, locked_q} <= 3'b000;
        end
        ST_LOAD:  st_q <= ST_SHIFT;
        ST_SHIFT: if (tick & sclk_q & (bit_q == dcfg_pkg::FRAME_LAST)) begin
          st_q <= ST_GAP;
        end
        ST_GAP:   if (tick) st_q <= ST_CHECK;
        ST_CHECK: begin
          if (timeout) begin
            fail_q <= 1'b1;  // [RQ16]
            st_q   <= ST_IDLE;
          end else if (at_poll & ~lock_ok) begin
            poll_q <= poll_q + 8'h01;  // Repeat the lock read [RQ13]
            st_q   <= ST_LOAD;
          end else if (step_q == LAST_STEP) begin
            done_q <= 1'b1;
            st_q   <= ST_IDLE;
          end else begin
            locked_q <= locked_q | at_poll;  // [RQ13]
            step_q   <= next_step;
            st_q     <= ST_LOAD;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Serial engine: data changes on the falling edge, sampled on rising
  always_ff @(posedge core_clk or negedge nrst) begin  // [RQ15]
    if (!nrst) begin
      frame_q <= 24'h000000;
      rx_q    <= 8'h00;
      bit_q   <= 5'd0;
      half_q  <= 4'h0;
      sclk_q  <= 1'b0;
      cs_n_q  <= 1'b1;
    end else if (st_q == ST_LOAD) begin
      frame_q <= frame_w;  // [RQ6] [RQ7] [RQ8] [RQ9] [RQ10] [RQ11] [RQ14]
      bit_q   <= 5'd0;
      half_q  <= 4'h0;
      cs_n_q  <= 1'b0;
    end else if (st_q == ST_SHIFT || st_q == ST_GAP) begin
      half_q <= tick ? 4'h0 : half_q + 4'h1;
      if (tick & (st_q == ST_SHIFT)) begin
        sclk_q <= ~sclk_q;
        if (!sclk_q) begin
          rx_q <= {rx_q[6:0], spi.sdo};
        end else if (bit_q == dcfg_pkg::FRAME_LAST) begin
          cs_n_q <= 1'b1;  // Frame ends with the last falling edge, in the same cycle
        end else begin
          bit_q   <= bit_q + 5'd1;
          frame_q <= {frame_q[22:0], 1'b0};
        end
      end
    end
  end

  // Outputs
  assign rdata    = rdata_q;
  assign irq      = |(irq_stat_q & irq_mask_q);
  assign spi.cs_n = cs_n_q;
  assign spi.sclk = sclk_q;
  assign spi.sdio = frame_q[dcfg_pkg::FRAME_RW];
endmodule : dcfg_host

/* testbench/dcfg_sva.sv */
`timescale 1ns/1ns
module dcfg_sva (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Serial wires
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdio,
  input wire logic sdo,
  input wire logic sdo_oe
);
  logic [4:0] rises_q; // Rising serial edges in this frame

  // Count rises; chip select high restarts the count
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) rises_q <= 5'h00;
    else if (cs_n) rises_q <= 5'h00;
    else if ($rose(sclk)) rises_q <= rises_q + 5'h01;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  oe_follows_cs_a: assert property (sdo_oe == !cs_n)
    else $error("sdo enable does not follow select");
  sclk_idle_a: assert property (cs_n |-> !sclk)
    else $error("serial clock runs outside a frame");
  sclk_high_a: assert property ($rose(sclk) |-> sclk [*2] ##1 !sclk)
    else $error("serial clock high phase wrong");
  sclk_low_a: assert property ($fell(sclk) |-> !sclk [*2])
    else $error("serial clock low phase short");
  sdio_hold_a: assert property (
    $rose(sclk) |-> $stable(sdio) ##1 $stable(sdio))
    else $error("data moved around the capture edge");
  cs_gap_a: assert property ($rose(cs_n) |-> cs_n [*2])
    else $error("gap between frames too short");
  frame_len_a: assert property ($rose(cs_n) |-> rises_q == 5'h18)
    else $error("frame is not 24 bits");
  sdo_edge_a: assert property (!cs_n && $changed(sdo) |-> !sclk)
    else $error("read data moved while clock high");
endmodule : dcfg_sva

/* testbench/tb.sv */
`timescale 1ns/1ns
module tb;
  logic       core_clk, nrst, wr, rd, pll_locked, irq; // Bench drives; irq comes from the host
  logic [2:0] addr;                                    // Host offset
  logic [7:0] wdata, rdata, v;                         // v: last read
  logic       bg_pd, m_pd, pll_en, fmt;                // Device levels
  logic [3:0] conv_pd;                                 // Converter mask
  logic [7:0] clk_pd, al_pd, odiv, rdiv, fbc, interp;  // Device bytes
  int         n_mismatch, total_checks;                // Tallies

  dcfg_if dcfg_if_inst ();
  dcfg_host dcfg_host_inst (.core_clk(core_clk), .nrst(nrst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .irq(irq), .spi(dcfg_if_inst.host));
  dcfg_device dcfg_device_inst (.core_clk(core_clk), .nrst(nrst),
    .spi(dcfg_if_inst.dev), .pll_locked(pll_locked),
    .bandgap_power_down(bg_pd), .master_power_down(m_pd),
    .converter_power_down_mask(conv_pd), .clock_power_down_mask(clk_pd),
    .alignment_input_power_down(al_pd), .pll_enable(pll_en),
    .pll_output_divider_select(odiv), .reference_divider_select(rdiv),
    .feedback_divider_count(fbc), .sample_number_format(fmt),
    .interpolation_select(interp));
  // Wire checker sits beside the link between both ends
  dcfg_sva dcfg_sva_inst (.core_clk(core_clk), .nrst(nrst),
    .cs_n(dcfg_if_inst.cs_n), .sclk(dcfg_if_inst.sclk),
    .sdio(dcfg_if_inst.sdio), .sdo(dcfg_if_inst.sdo),
    .sdo_oe(dcfg_if_inst.sdo_oe));

  // Compare and tally
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One-cycle write strobe
  task wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge core_clk);
    wr    <= 1'b0;
  endtask : wreg

  // Read data stand from the cycle after the strobe until the next read
  task rreg(input logic [2:0] a);
    @(posedge core_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge core_clk);
    rd   <= 1'b0;
    #1 v = rdata;
  endtask : rreg

  task finish_test;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test

  // Start a run and poll status until done or fail, bounded
  task run_setup(input logic [7:0] ctrl, input logic [7:0] mask);
    int i;
    wreg(dcfg_pkg::H_IRQ_MASK, mask);
    wreg(dcfg_pkg::H_CTRL, ctrl | 8'h01);
    for (i = 0; i < 400; i++) begin
      repeat (100) @(posedge core_clk);
      rreg(dcfg_pkg::H_STATUS);
      if (v[2:1] !== 2'h0) break;
    end
    if (i == 400) begin
      n_mismatch++;
      finish_test();
    end
  endtask : run_setup

  // Full run with the converter PLL locking
  task test_pll_lock;
    pll_locked <= 1'b1;
    wreg(dcfg_pkg::H_INTERP, 8'h03);
    wreg(dcfg_pkg::H_PLL_OUT, 8'h21);
    wreg(dcfg_pkg::H_PLL_REF, 8'h42);
    wreg(dcfg_pkg::H_PLL_FB, 8'h13);
    run_setup(8'h0E, 8'h03);
    chk(v, 8'h0A);
    chk({7'h00, irq}, 8'h01);
    chk({bg_pd, conv_pd, m_pd, 2'h0}, 8'h00);
    chk(clk_pd, 8'h00);
    chk(al_pd, 8'h10);
    chk({7'h00, pll_en}, 8'h01);
    chk(odiv, 8'h21);
    chk(rdiv, 8'h42);
    chk(fbc, 8'h13);
    chk({7'h00, fmt}, 8'h01);
    chk(interp, 8'h03);
    rreg(dcfg_pkg::H_IRQ_STAT);
    chk(v, 8'h01);
    rreg(dcfg_pkg::H_IRQ_STAT);
    chk({v[6:0], irq}, 8'h00);
    rreg(dcfg_pkg::H_CTRL);
    chk(v, 8'h0E);
  endtask : test_pll_lock

  // No PLL, masked done; soft reset must clear earlier PLL setup
  task test_no_pll_masked;
    pll_locked <= 1'b0;
    wreg(dcfg_pkg::H_STATUS, 8'hFF);
    run_setup(8'h00, 8'h02);
    chk(v, 8'h02);
    chk({7'h00, irq}, 8'h00);
    chk(al_pd, 8'h00);
    chk({7'h00, fmt}, 8'h00);
    chk(odiv, 8'h00);
    chk({7'h00, pll_en}, 8'h00);
    rreg(dcfg_pkg::H_IRQ_STAT);
    chk(v, 8'h01);
  endtask : test_no_pll_masked

  // PLL never locks: bounded poll ends in failure
  task test_lock_timeout;
    run_setup(8'h02, 8'h03);
    chk(v, 8'h04);
    chk({7'h00, irq}, 8'h01);
    chk({7'h00, pll_en}, 8'h01);
    rreg(dcfg_pkg::H_IRQ_STAT);
    chk(v, 8'h02);
  endtask : test_lock_timeout

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  initial begin
    nrst = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    pll_locked = 1'b0;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    test_pll_lock();
    test_no_pll_masked();
    test_lock_timeout();
    finish_test();
  end
endmodule : tb
